// File: pkg/frt_pkg.sv
// Purpose: Constants for the free running timer with input capture
// Assumes: 32-bit APB, byte wide registers, one register per word
// Notes:   Register indices are word numbers; byte address is 4 x index
package frt_pkg;
    // ---------------------------------------------------------------
    // Register indices
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL     = 8'h12;
    localparam logic [7:0] IDX_STAT     = 8'h13;
    localparam logic [7:0] IDX_CAP1_HI  = 8'h14;
    localparam logic [7:0] IDX_CAP1_LO  = 8'h15;
    localparam logic [7:0] IDX_CNT_HI   = 8'h18;
    localparam logic [7:0] IDX_CNT_LO   = 8'h19;
    localparam logic [7:0] IDX_ALT_HI   = 8'h1a;
    localparam logic [7:0] IDX_ALT_LO   = 8'h1b;
    localparam logic [7:0] IDX_CAP2_HI  = 8'h1c;
    localparam logic [7:0] IDX_CAP2_LO  = 8'h1d;
    localparam logic [7:0] IDX_MISC     = 8'h20;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTRL_CAP_IE  = 7;
    localparam int CTRL_OVF_IE  = 5;
    localparam int CTRL_EDGE1   = 1;
    localparam int STAT_CAP1    = 7;
    localparam int STAT_OVF     = 5;
    localparam int STAT_CAP2    = 4;
    localparam int MISC_HS_DIV  = 0;

    // ---------------------------------------------------------------
    // Reset values and timing
    // ---------------------------------------------------------------
    localparam logic [15:0] CNT_RESET   = 16'hfffc;
    localparam logic [15:0] CNT_TOP     = 16'hffff;
    localparam logic [7:0]  HS_DIV_LAST = 8'hff;
    localparam int          CLK_MHZ     = 25;
    localparam int          STARTUP_NS  = 640;
    localparam int          STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;

    function automatic logic [15:0] inc16(input logic [15:0] v);
        return v + 16'h0001;
    endfunction : inc16
endpackage : frt_pkg

// File: pkg/frt_cap_if.sv
// Purpose: Signals between the timer core and one capture channel
// Assumes: Single clock domain
// Notes:   chan side is the capture channel
`timescale 1ns/1ps
interface frt_cap_if;
    logic [15:0] count;
    logic        halt;
    logic        evt;
    logic        rd_high;
    logic        rd_low;
    logic [15:0] value;
    logic        flag_set;
    modport chan (input count, halt, evt, rd_high, rd_low, output value, flag_set);
    modport ctrl (output count, halt, evt, rd_high, rd_low, input value, flag_set);
endinterface : frt_cap_if

// File: src/frt_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module frt_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule : frt_sync

// File: src/frt_capture.sv
// Purpose: One input capture channel with read inhibit and halt arming
// Assumes: evt is a one-cycle pulse on a qualified edge
// Notes:   Captured value has no reset on purpose
`timescale 1ns/1ps
module frt_capture (
    input  wire logic clk,
    input  wire logic rst_n,
    frt_cap_if.chan   cap
);
    logic        inhibit_q;
    logic        armed_q;
    logic        flag_q;
    logic [15:0] value_q;
    wire         take = cap.evt & ~inhibit_q & ~(cap.halt & armed_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inhibit_q <= 1'b0;
            armed_q   <= 1'b0;
            flag_q    <= 1'b0;
        end else begin
            if (cap.rd_high)
                inhibit_q <= 1'b1;
            else if (cap.rd_low)
                inhibit_q <= 1'b0;
            armed_q <= cap.halt & (armed_q | cap.evt);
            flag_q  <= ~cap.halt & (cap.evt | armed_q);
        end
    end

    // No reset: contents undefined at power-on, kept over external reset
    always_ff @(posedge clk) begin
        if (take)
            value_q <= frt_pkg::inc16(cap.count);
    end

    assign cap.value    = value_q;
    assign cap.flag_set = flag_q;

    a_capture_value: assert property (@(posedge clk) disable iff (!rst_n)
        take |=> value_q == frt_pkg::inc16($past(cap.count)))
        else $error("capture value is not count plus one");
    a_inhibit_hold: assert property (@(posedge clk) disable iff (!rst_n)
        inhibit_q && !cap.rd_low |=> $stable(value_q))
        else $error("capture changed while inhibited");
endmodule : frt_capture

// File: src/frt_top.sv
// Purpose: 16-bit free running timer with two input capture channels
// Assumes: pclk is the processor clock; halt and cpu_irq_mask share it
// Notes:   Registers are byte wide, one per APB word, upper bits zero
`timescale 1ns/1ps

module frt_top #(
    parameter int STARTUP_CYC = frt_pkg::STARTUP_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        halt,
    input  wire logic        cpu_irq_mask,
    input  wire logic        capture_input_one,
    input  wire logic        horiz_sync_in,
    output logic             timer_irq
);
    localparam int SW = $clog2(STARTUP_CYC + 1);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [15:0]   count_q;
    logic          presc_q;
    logic [SW-1:0] start_cnt_q;
    logic          started_q;
    logic          ovf_q;
    logic          cap1_q;
    logic          cap2_q;
    logic [2:0]    seen_q;
    logic          cap_ie_q;
    logic          ovf_ie_q;
    logic          edge_sel_q;
    logic          hs_div_en_q;
    logic [7:0]    hs_div_q;
    logic [1:0]    pin_prev_q;
    logic          buf_valid_q;
    logic [7:0]    buf_lo_q;
    logic [7:0]    snap_lo_q;
    logic          ready_q;
    logic          err_q;
    logic [31:0]   rdata_q;
    logic          irq_q;
    logic [1:0]    pins_s;
    logic [7:0]    rd_mux;

    frt_cap_if c1 ();
    frt_cap_if c2 ();

    // ---------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ---------------------------------------------------------------
    frt_sync #(
        .W     (2)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .din   ({capture_input_one, horiz_sync_in}),
        .dout  (pins_s)
    );

    // Edge detectors compare levels over time, so a change of edge
    // select alone never creates an event
    wire ic1_rise = pins_s[1] & ~pin_prev_q[1];
    wire ic1_fall = ~pins_s[1] & pin_prev_q[1];
    wire hs_fall  = ~pins_s[0] & pin_prev_q[0];
    wire hs_tick  = hs_fall & (hs_div_q == frt_pkg::HS_DIV_LAST);
    wire ev1      = edge_sel_q ? ic1_rise : ic1_fall;
    wire ev2      = hs_div_en_q ? hs_tick : hs_fall;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev_q <= 2'h0;
            hs_div_q   <= 8'h00;
        end else begin
            pin_prev_q <= pins_s;
            if (hs_fall)
                hs_div_q <= hs_div_q + 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    wire [7:0] idx      = paddr[9:2];
    wire       aligned  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    wire       setup    = psel & ~penable;
    wire       acc      = psel & penable & ready_q;
    wire       rd       = acc & ~pwrite;
    wire       wr       = acc & pwrite;
    wire       hit_ctrl = aligned && (idx == frt_pkg::IDX_CTRL);
    wire       hit_stat = aligned && (idx == frt_pkg::IDX_STAT);
    wire       hit_c1hi = aligned && (idx == frt_pkg::IDX_CAP1_HI);
    wire       hit_c1lo = aligned && (idx == frt_pkg::IDX_CAP1_LO);
    wire       hit_cnhi = aligned && (idx == frt_pkg::IDX_CNT_HI);
    wire       hit_cnlo = aligned && (idx == frt_pkg::IDX_CNT_LO);
    wire       hit_alhi = aligned && (idx == frt_pkg::IDX_ALT_HI);
    wire       hit_allo = aligned && (idx == frt_pkg::IDX_ALT_LO);
    wire       hit_c2hi = aligned && (idx == frt_pkg::IDX_CAP2_HI);
    wire       hit_c2lo = aligned && (idx == frt_pkg::IDX_CAP2_LO);
    wire       hit_misc = aligned && (idx == frt_pkg::IDX_MISC);
    wire       mapped   = hit_ctrl | hit_stat | hit_c1hi | hit_c1lo | hit_cnhi
                        | hit_cnlo | hit_alhi | hit_allo | hit_c2hi | hit_c2lo
                        | hit_misc;

    wire       cnt_lo_acc = acc & hit_cnlo;
    wire       alt_acc    = acc & (hit_alhi | hit_allo);
    wire       cnt_hi_rd  = rd & (hit_cnhi | hit_alhi);
    wire       cnt_lo_rd  = rd & (hit_cnlo | hit_allo);
    wire       soft_rst   = wr & (hit_cnlo | hit_allo);
    wire       stat_rd    = rd & hit_stat;
    wire       c1_lo_acc  = acc & hit_c1lo;
    wire       c2_lo_acc  = acc & hit_c2lo;

    // ---------------------------------------------------------------
    // Counter and prescaler
    // ---------------------------------------------------------------
    wire run     = started_q & ~halt;
    wire tick    = presc_q & run;
    wire ovf_set = tick & (count_q == frt_pkg::CNT_TOP) & ~soft_rst;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= frt_pkg::CNT_RESET;
            presc_q <= 1'b0;
        end else if (soft_rst) begin
            count_q <= frt_pkg::CNT_RESET;
            presc_q <= 1'b0;
        end else begin
            presc_q <= presc_q ^ run;
            if (tick)
                count_q <= frt_pkg::inc16(count_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_cnt_q <= '0;
            started_q   <= 1'b0;
        end else if (!started_q) begin
            start_cnt_q <= start_cnt_q + 1'b1;
            started_q   <= (start_cnt_q == SW'(STARTUP_CYC));
        end
    end

    // ---------------------------------------------------------------
    // Counter read buffer
    // ---------------------------------------------------------------
    // The low byte is snapped at the setup edge, the same edge that
    // samples the high byte, so both halves come from one count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_valid_q <= 1'b0;
            buf_lo_q    <= 8'h00;
            snap_lo_q   <= 8'h00;
        end else begin
            if (setup)
                snap_lo_q <= count_q[7:0];
            if (soft_rst || cnt_lo_rd) begin
                buf_valid_q <= 1'b0;
            end else if (cnt_hi_rd && !buf_valid_q) begin
                buf_valid_q <= 1'b1;
                buf_lo_q    <= snap_lo_q;
            end
        end
    end

    // ---------------------------------------------------------------
    // Capture channels
    // ---------------------------------------------------------------
    assign c1.count   = count_q;
    assign c1.halt    = halt;
    assign c1.evt     = ev1;
    assign c1.rd_high = rd & hit_c1hi;
    assign c1.rd_low  = rd & hit_c1lo;
    assign c2.count   = count_q;
    assign c2.halt    = halt;
    assign c2.evt     = ev2;
    assign c2.rd_high = rd & hit_c2hi;
    assign c2.rd_low  = rd & hit_c2lo;

    frt_capture u_cap1 (
        .clk   (pclk),
        .rst_n (presetn),
        .cap   (c1.chan)
    );

    frt_capture u_cap2 (
        .clk   (pclk),
        .rst_n (presetn),
        .cap   (c2.chan)
    );

    // ---------------------------------------------------------------
    // Flags, clear sequences and control
    // ---------------------------------------------------------------
    wire ovf_clr  = seen_q[1] & cnt_lo_acc;
    wire cap1_clr = seen_q[2] & c1_lo_acc;
    wire cap2_clr = seen_q[0] & c2_lo_acc;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q  <= 1'b0;
            cap1_q <= 1'b0;
            cap2_q <= 1'b0;
            seen_q <= 3'h0;
        end else begin
            ovf_q     <= ovf_set | (ovf_q & ~ovf_clr);
            cap1_q    <= c1.flag_set | (cap1_q & ~cap1_clr);
            cap2_q    <= c2.flag_set | (cap2_q & ~cap2_clr);
            seen_q[2] <= (stat_rd & rdata_q[frt_pkg::STAT_CAP1]) | (seen_q[2] & ~c1_lo_acc);
            seen_q[1] <= (stat_rd & rdata_q[frt_pkg::STAT_OVF]) | (seen_q[1] & ~cnt_lo_acc);
            seen_q[0] <= (stat_rd & rdata_q[frt_pkg::STAT_CAP2]) | (seen_q[0] & ~c2_lo_acc);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_ie_q    <= 1'b0;
            ovf_ie_q    <= 1'b0;
            edge_sel_q  <= 1'b0;
            hs_div_en_q <= 1'b0;
        end else if (wr && hit_ctrl) begin
            cap_ie_q   <= pwdata[frt_pkg::CTRL_CAP_IE];
            ovf_ie_q   <= pwdata[frt_pkg::CTRL_OVF_IE];
            edge_sel_q <= pwdata[frt_pkg::CTRL_EDGE1];
        end else if (wr && hit_misc) begin
            hs_div_en_q <= pwdata[frt_pkg::MISC_HS_DIV];
        end
    end

    // ---------------------------------------------------------------
    // Interrupt request
    // ---------------------------------------------------------------
    wire irq_src = (ovf_q & ovf_ie_q) | ((cap1_q | cap2_q) & cap_ie_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_q <= 1'b0;
        else
            irq_q <= irq_src & ~cpu_irq_mask;
    end

    // ---------------------------------------------------------------
    // Read data and APB answer
    // ---------------------------------------------------------------
    always_comb begin
        rd_mux = 8'h00;
        if (hit_ctrl) begin
            rd_mux[frt_pkg::CTRL_CAP_IE] = cap_ie_q;
            rd_mux[frt_pkg::CTRL_OVF_IE] = ovf_ie_q;
            rd_mux[frt_pkg::CTRL_EDGE1]  = edge_sel_q;
        end else if (hit_stat) begin
            rd_mux[frt_pkg::STAT_CAP1] = cap1_q;
            rd_mux[frt_pkg::STAT_OVF]  = ovf_q;
            rd_mux[frt_pkg::STAT_CAP2] = cap2_q;
        end else if (hit_c1hi) begin
            rd_mux = c1.value[15:8];
        end else if (hit_c1lo) begin
            rd_mux = c1.value[7:0];
        end else if (hit_cnhi || hit_alhi) begin
            rd_mux = count_q[15:8];
        end else if (hit_cnlo || hit_allo) begin
            rd_mux = buf_valid_q ? buf_lo_q : count_q[7:0];
        end else if (hit_c2hi) begin
            rd_mux = c2.value[15:8];
        end else if (hit_c2lo) begin
            rd_mux = c2.value[7:0];
        end else if (hit_misc) begin
            rd_mux[frt_pkg::MISC_HS_DIV] = hs_div_en_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ready_q <= setup;
            err_q   <= setup & ~mapped;
            if (setup)
                rdata_q <= {24'h00_0000, rd_mux};
        end
    end

    assign prdata    = rdata_q;
    assign pready    = ready_q;
    assign pslverr   = err_q;
    assign timer_irq = irq_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence s_stat_seen;
        stat_rd && rdata_q[frt_pkg::STAT_OVF];
    endsequence

    sequence s_lo_touch;
        cnt_lo_acc && seen_q[1] && !ovf_set;
    endsequence

    a_ovf_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_set |=> ovf_q && count_q == 16'h0000)
        else $error("wrap did not set overflow");
    a_ovf_clear_seq: assert property (@(posedge pclk) disable iff (!presetn)
        s_stat_seen ##[2:20] s_lo_touch |=> !ovf_q)
        else $error("overflow not cleared by read sequence");
    a_alt_keeps_flag: assert property (@(posedge pclk) disable iff (!presetn)
        alt_acc && ovf_q |=> ovf_q)
        else $error("alternate access cleared overflow");
    a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_q && ovf_ie_q && !cpu_irq_mask |=> timer_irq)
        else $error("enabled overflow gave no interrupt");
    a_soft_reset_load: assert property (@(posedge pclk) disable iff (!presetn)
        soft_rst |=> count_q == frt_pkg::CNT_RESET && !buf_valid_q && !presc_q)
        else $error("low byte write did not reset counter");
    a_halt_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
        halt && !soft_rst |=> $stable(count_q))
        else $error("counter moved during halt");
    a_buf_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        buf_valid_q && !soft_rst && !cnt_lo_rd |=> buf_valid_q && $stable(buf_lo_q))
        else $error("read buffer changed before low read");
    a_startup_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !started_q |-> count_q == frt_pkg::CNT_RESET)
        else $error("counter ran before startup delay");
    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");
endmodule : frt_top

// File: verif/frt_sig_src.sv
// Purpose: Far-side source of the two capture pins
// Assumes: Pins change right after a rising pclk edge
// Notes:   Levels are held until the next call
`timescale 1ns/1ps
module frt_sig_src (
    input  wire logic clk,
    output logic      cap_one,
    output logic      hsync
);
    initial begin
        cap_one = 1'b0;
        hsync   = 1'b1;
    end
    task automatic set_pins(input logic c, input logic h);
        @(posedge clk);
        cap_one <= c;
        hsync   <= h;
    endtask : set_pins
endmodule : frt_sig_src

// File: verif/tb_top.sv
// Purpose: Register level test of the timer with input capture
// Assumes: Startup delay shortened to one cycle
// Notes:   Counter reads checked by ranges; capture values checked as exact counts
`timescale 1ns/1ps
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        halt = 1'b0;
    logic        cpu_irq_mask = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timer_irq;
    logic        cap_one;
    logic        hsync;
    logic [7:0]  rd;
    logic [7:0]  keep;
    logic [15:0] exp16;
    logic        er;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cycles = 0;

    always #20 pclk = ~pclk;

    frt_top #(.STARTUP_CYC(1)) i_frt_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .halt(halt), .cpu_irq_mask(cpu_irq_mask),
        .capture_input_one(cap_one), .horiz_sync_in(hsync), .timer_irq(timer_irq)
    );
    frt_sig_src i_frt_sig_src (.clk(pclk), .cap_one(cap_one), .hsync(hsync));

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : acc

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            conclude();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        acc(0, frt_pkg::IDX_CNT_HI, 8'h00);
        chk("count_high after reset", rd, 8'hff);
        acc(1, frt_pkg::IDX_ALT_LO, 8'h00);
        acc(0, frt_pkg::IDX_ALT_HI, 8'h00);
        repeat (40) @(posedge pclk);
        acc(0, frt_pkg::IDX_CNT_HI, 8'h00);
        chk("count_high live", rd, 8'h00);
        acc(0, frt_pkg::IDX_CNT_LO, 8'h00);
        chk("buffered low", rd & 8'hfc, 8'hfc);
        repeat (20) @(posedge pclk);
        acc(0, frt_pkg::IDX_CNT_LO, 8'h00);
        chk("live low", rd & 8'hc0, 8'h00);
        acc(0, frt_pkg::IDX_STAT, 8'h00);
        chk("status overflow", rd, 8'h20);
        acc(0, frt_pkg::IDX_ALT_LO, 8'h00);
        acc(1, frt_pkg::IDX_CTRL, 8'h20);
        acc(0, frt_pkg::IDX_CTRL, 8'h00);
        chk("control", rd, 8'h20);
        chk("irq on overflow", {7'h0, timer_irq}, 8'h01);
        cpu_irq_mask <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("irq masked", {7'h0, timer_irq}, 8'h00);
        cpu_irq_mask <= 1'b0;
        acc(0, frt_pkg::IDX_STAT, 8'h00);
        chk("overflow kept", rd, 8'h20);
        acc(0, frt_pkg::IDX_CNT_LO, 8'h00);
        acc(0, frt_pkg::IDX_STAT, 8'h00);
        chk("overflow cleared", rd, 8'h00);
        chk("irq cleared", {7'h0, timer_irq}, 8'h00);
        halt <= 1'b1;
        acc(0, frt_pkg::IDX_ALT_LO, 8'h00);
        keep = rd;
        repeat (20) @(posedge pclk);
        acc(0, frt_pkg::IDX_ALT_LO, 8'h00);
        chk("count held in halt", rd, keep);
        halt <= 1'b0;
        acc(1, frt_pkg::IDX_CTRL, 8'h82);
        // Snapshot count, then the edge is taken four ticks later
        acc(0, frt_pkg::IDX_ALT_HI, 8'h00);
        exp16[15:8] = rd;
        acc(0, frt_pkg::IDX_ALT_LO, 8'h00);
        exp16 = {exp16[15:8], rd} + 16'h0005;
        i_frt_sig_src.set_pins(1'b1, 1'b1);
        repeat (8) @(posedge pclk);
        acc(0, frt_pkg::IDX_STAT, 8'h00);
        chk("rising capture", rd, 8'h80);
        chk("capture irq", {7'h0, timer_irq}, 8'h01);
        acc(0, frt_pkg::IDX_CAP1_HI, 8'h00);
        chk("capture one high", rd, exp16[15:8]);
        i_frt_sig_src.set_pins(1'b0, 1'b1);
        i_frt_sig_src.set_pins(1'b1, 1'b1);
        repeat (8) @(posedge pclk);
        acc(0, frt_pkg::IDX_CAP1_LO, 8'h00);
        chk("capture one low kept", rd, exp16[7:0]);
        i_frt_sig_src.set_pins(1'b0, 1'b1);
        repeat (8) @(posedge pclk);
        acc(0, frt_pkg::IDX_STAT, 8'h00);
        chk("flag one cleared", rd, 8'h00);
        acc(1, frt_pkg::IDX_CTRL, 8'h80);
        i_frt_sig_src.set_pins(1'b1, 1'b1);
        i_frt_sig_src.set_pins(1'b0, 1'b0);
        repeat (8) @(posedge pclk);
        acc(0, frt_pkg::IDX_STAT, 8'h00);
        chk("falling captures", rd, 8'h90);
        acc(0, frt_pkg::IDX_CAP1_LO, 8'h00);
        acc(0, frt_pkg::IDX_CAP2_LO, 8'h00);
        acc(1, frt_pkg::IDX_MISC, 8'h01);
        for (int i = 0; i < 512; i++) begin
            i_frt_sig_src.set_pins(1'b0, 1'b1);
            i_frt_sig_src.set_pins(1'b0, 1'b0);
            if (i == 100) begin
                acc(0, frt_pkg::IDX_STAT, 8'h00);
                chk("divided sync quiet", rd, 8'h00);
            end
        end
        repeat (8) @(posedge pclk);
        acc(0, frt_pkg::IDX_STAT, 8'h00);
        chk("divided sync capture", rd, 8'h10);
        acc(0, frt_pkg::IDX_CAP2_LO, 8'h00);
        // Edge in halt captures data and arms; the flag appears on wake
        halt <= 1'b1;
        acc(0, frt_pkg::IDX_ALT_HI, 8'h00);
        exp16[15:8] = rd;
        acc(0, frt_pkg::IDX_ALT_LO, 8'h00);
        exp16 = {exp16[15:8], rd} + 16'h0001;
        i_frt_sig_src.set_pins(1'b1, 1'b0);
        i_frt_sig_src.set_pins(1'b0, 1'b0);
        repeat (8) @(posedge pclk);
        acc(0, frt_pkg::IDX_STAT, 8'h00);
        chk("halt edge arms only", rd, 8'h00);
        chk("halt irq quiet", {7'h0, timer_irq}, 8'h00);
        halt <= 1'b0;
        repeat (8) @(posedge pclk);
        acc(0, frt_pkg::IDX_STAT, 8'h00);
        chk("wake capture flag", rd, 8'h80);
        acc(0, frt_pkg::IDX_CAP1_HI, 8'h00);
        chk("halt capture high", rd, exp16[15:8]);
        acc(0, frt_pkg::IDX_CAP1_LO, 8'h00);
        chk("halt capture low", rd, exp16[7:0]);
        acc(0, 8'h30, 8'h00);
        chk("unmapped error", {7'h0, er}, 8'h01);
        chk("unmapped data", rd, 8'h00);
        conclude();
    end
endmodule : tb_top
